//--- src/bsq_sequencer.sv
module bsq_sequencer #(
    parameter int TICK_CYCLES = bsq_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // field inputs, asynchronous
    input wire logic thermostat_i,
    input wire logic preheat_ready_i,
    input wire logic flame_i,
    input wire logic button_i,
    input wire logic undervolt_i,
    input wire logic fault_i,
    // nonvolatile cause store
    input wire logic [2:0] nv_cause_i,
    output logic nv_wr_o,
    output logic [2:0] nv_cause_o,
    // burner outputs and indicator
    output logic motor_o,
    output logic ignition_o,
    output logic valve1_o,
    output logic valve2_o,
    output logic preheater_o,
    output logic alarm_o,
    output logic led_o
);
    localparam int NIN = 6;
    localparam int PW = $clog2(TICK_CYCLES + 1);

    // symbol count in [7:5], long mask in [4:0]
    function automatic logic [bsq_pkg::CODE_W-1:0] code_of(input logic [3:0] st,
                                                           input logic [2:0] ca);
        logic [bsq_pkg::CODE_W-1:0] c;
        c = {3'h1, 5'h00};
        if (st == bsq_pkg::ST_LOCK)
        begin
            case (ca)
                bsq_pkg::CA_NOFLAME: c = {3'h5, 5'h00};
                bsq_pkg::CA_STRAY: c = {3'h3, 5'h02};
                bsq_pkg::CA_THERMO: c = {3'h5, 5'h18};
                default: c = {3'h5, 5'h1f};
            endcase
        end
        else
        begin
            case (st)
                bsq_pkg::ST_WAIT, bsq_pkg::ST_PREHEAT: c = {3'h2, 5'h00};
                bsq_pkg::ST_PURGE: c = {3'h4, 5'h00};
                bsq_pkg::ST_SAFETY, bsq_pkg::ST_POST: c = {3'h2, 5'h01};
                bsq_pkg::ST_STAGE2: c = {3'h3, 5'h01};
                bsq_pkg::ST_UNDERV: c = {3'h3, 5'h00};
                bsq_pkg::ST_DEFECT: c = {3'h2, 5'h02};
                default: c = {3'h1, 5'h00};
            endcase
        end
        return c;
    endfunction : code_of

    // three-stage input synchronisers; a level counts when stages two and three agree
    logic [NIN-1:0] s1_reg, s2_reg, s3_reg, in_reg, in_next;
    wire [NIN-1:0] pins = {fault_i, undervolt_i, button_i, flame_i, preheat_ready_i,
                           thermostat_i};
    assign in_next = (s2_reg == s3_reg) ? s3_reg : in_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            in_reg <= '0;
        end
        else
        begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            in_reg <= in_next;
        end
    end
    wire therm = in_reg[0];
    wire pre_ok = in_reg[1];
    wire flame = in_reg[2];
    wire btn = in_reg[3];
    wire uv = in_reg[4];
    wire defect = in_reg[5];

    // single timebase
    logic [PW-1:0] pre_reg;
    logic tick_reg;
    wire pre_end = (pre_reg == PW'(TICK_CYCLES - 1));
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_end ? '0 : pre_reg + PW'(1);
            tick_reg <= pre_end;
        end
    end

    // wishbone slave
    logic ack_reg, two_stage_reg;
    logic [31:0] dat_reg;
    wire bus_req = cyc_i & stb_i & ~ack_reg;
    wire ctrl_wr = bus_req & we_i & sel_i[0] & (adr_i == bsq_pkg::CTRL_ADDR);

    // button hold measurement
    logic btn_d_reg;
    logic [bsq_pkg::TW-1:0] hold_reg;
    wire btn_rel = btn_d_reg & ~btn;
    wire long_rel = btn_rel & (hold_reg > bsq_pkg::BTN_HOLD_T);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            btn_d_reg <= 1'b0;
            hold_reg <= '0;
        end
        else
        begin
            btn_d_reg <= btn;
            if (!btn)
                hold_reg <= '0;
            else if (tick_reg && hold_reg != bsq_pkg::PREHEAT_MAX_T)
                hold_reg <= hold_reg + bsq_pkg::TW'(1);
        end
    end

    // sequencer
    bsq_pkg::bsq_state_t st_reg, st_next;
    bsq_pkg::bsq_cause_t cause_reg, cause_next;
    logic [bsq_pkg::TW-1:0] ph_reg;
    logic boot_reg;
    wire active = (st_reg != bsq_pkg::ST_LOCK) && (st_reg != bsq_pkg::ST_UNDERV)
                  && (st_reg != bsq_pkg::ST_DEFECT);
    wire running_phase = active && (st_reg != bsq_pkg::ST_WAIT);
    logic [bsq_pkg::TW-1:0] ph_len;
    always_comb
    begin
        case (st_reg)
            bsq_pkg::ST_PREHEAT: ph_len = bsq_pkg::PREHEAT_MAX_T;
            bsq_pkg::ST_PURGE: ph_len = bsq_pkg::PREPURGE_T;
            bsq_pkg::ST_SAFETY: ph_len = bsq_pkg::SAFETY_T;
            bsq_pkg::ST_POST: ph_len = bsq_pkg::POST_REST_T;
            bsq_pkg::ST_STAGE2: ph_len = bsq_pkg::STAGE2_REST_T;
            default: ph_len = bsq_pkg::PREHEAT_MAX_T;
        endcase
    end
    wire ph_end = tick_reg && (ph_reg >= ph_len - bsq_pkg::TW'(1));

    always_comb
    begin
        st_next = st_reg;
        cause_next = cause_reg;
        if (boot_reg)
        begin
            // a cause stored before power loss puts us straight back into lockout
            if (nv_cause_i != bsq_pkg::CA_NONE)
            begin
                st_next = bsq_pkg::ST_LOCK;
                cause_next = bsq_pkg::bsq_cause_t'(nv_cause_i);
            end
        end
        else if (st_reg == bsq_pkg::ST_LOCK)
        begin
            if (btn_rel)
            begin
                st_next = bsq_pkg::ST_WAIT;
                cause_next = bsq_pkg::CA_NONE;
            end
        end
        else if (defect)
            st_next = bsq_pkg::ST_DEFECT;
        else if (uv)
            st_next = bsq_pkg::ST_UNDERV;
        else if (st_reg == bsq_pkg::ST_UNDERV || st_reg == bsq_pkg::ST_DEFECT)
            st_next = bsq_pkg::ST_WAIT;
        else if (long_rel)
        begin
            st_next = bsq_pkg::ST_LOCK;
            cause_next = bsq_pkg::CA_MANUAL;
        end
        else if (running_phase && !therm)
            st_next = bsq_pkg::ST_WAIT;
        else
        begin
            case (st_reg)
                bsq_pkg::ST_WAIT:
                    if (therm)
                        st_next = bsq_pkg::ST_PREHEAT;
                bsq_pkg::ST_PREHEAT:
                    if (pre_ok)
                        st_next = bsq_pkg::ST_PURGE;
                    else if (ph_end)
                    begin
                        st_next = bsq_pkg::ST_LOCK;
                        cause_next = bsq_pkg::CA_THERMO;
                    end
                bsq_pkg::ST_PURGE:
                    if (flame && ph_reg >= bsq_pkg::STRAY_START_T)
                    begin
                        st_next = bsq_pkg::ST_LOCK;
                        cause_next = bsq_pkg::CA_STRAY;
                    end
                    else if (ph_end)
                        st_next = bsq_pkg::ST_SAFETY;
                bsq_pkg::ST_SAFETY:
                    if (ph_end)
                    begin
                        if (flame)
                            st_next = bsq_pkg::ST_POST;
                        else
                        begin
                            st_next = bsq_pkg::ST_LOCK;
                            cause_next = bsq_pkg::CA_NOFLAME;
                        end
                    end
                bsq_pkg::ST_POST, bsq_pkg::ST_STAGE2, bsq_pkg::ST_RUN:
                    if (!flame)
                    begin
                        st_next = bsq_pkg::ST_LOCK;
                        cause_next = bsq_pkg::CA_NOFLAME;
                    end
                    else if (ph_end && st_reg == bsq_pkg::ST_POST)
                        st_next = two_stage_reg ? bsq_pkg::ST_STAGE2 : bsq_pkg::ST_RUN;
                    else if (ph_end && st_reg == bsq_pkg::ST_STAGE2)
                        st_next = bsq_pkg::ST_RUN;
                default: st_next = st_reg;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= bsq_pkg::ST_WAIT;
            cause_reg <= bsq_pkg::CA_NONE;
            ph_reg <= '0;
            boot_reg <= 1'b1;
            nv_wr_o <= 1'b0;
            nv_cause_o <= bsq_pkg::CA_NONE;
        end
        else
        begin
            st_reg <= st_next;
            cause_reg <= cause_next;
            boot_reg <= 1'b0;
            if (st_next != st_reg)
                ph_reg <= '0;
            else if (tick_reg && st_reg != bsq_pkg::ST_RUN)
                ph_reg <= ph_reg + bsq_pkg::TW'(1);
            // the store follows every change of cause except the restore in the boot cycle, clearing included
            nv_wr_o <= !boot_reg && (cause_next != cause_reg);
            nv_cause_o <= cause_next;
        end
    end

    // outputs
    wire v1_on = (st_reg == bsq_pkg::ST_SAFETY) || (st_reg == bsq_pkg::ST_POST)
                 || (st_reg == bsq_pkg::ST_STAGE2) || (st_reg == bsq_pkg::ST_RUN);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            motor_o <= 1'b0;
            ignition_o <= 1'b0;
            valve1_o <= 1'b0;
            valve2_o <= 1'b0;
            preheater_o <= 1'b0;
            alarm_o <= 1'b0;
        end
        else
        begin
            motor_o <= (st_reg == bsq_pkg::ST_PURGE) || v1_on;
            ignition_o <= (st_reg == bsq_pkg::ST_PURGE) || (st_reg == bsq_pkg::ST_SAFETY)
                          || (st_reg == bsq_pkg::ST_POST);
            valve1_o <= v1_on;
            valve2_o <= (st_reg == bsq_pkg::ST_RUN) && two_stage_reg;
            // the heater stays fed in lockout, as the wiring does
            preheater_o <= running_phase || (st_reg == bsq_pkg::ST_LOCK);
            alarm_o <= (st_reg == bsq_pkg::ST_LOCK);
        end
    end

    // led sequencer
    bsq_pkg::bsq_led_t ld_reg, ld_next;
    logic [bsq_pkg::TW-1:0] lt_reg;
    logic [2:0] sym_reg;
    logic led_reg;
    wire lock = (st_reg == bsq_pkg::ST_LOCK);
    wire [bsq_pkg::CODE_W-1:0] code = code_of(st_reg, cause_reg);
    wire [2:0] code_len = code[7:5];
    wire sym_long = code[sym_reg];
    wire last_sym = (sym_reg + 3'h1 >= code_len);
    logic [bsq_pkg::TW-1:0] ld_len;
    always_comb
    begin
        case (ld_reg)
            bsq_pkg::LD_LIT: ld_len = bsq_pkg::LOCK_LIT_T;
            bsq_pkg::LD_DARK1: ld_len = bsq_pkg::LOCK_DARK1_T;
            bsq_pkg::LD_SYM_ON: ld_len = sym_long ? bsq_pkg::PULSE_LONG_T : bsq_pkg::PULSE_SHORT_T;
            bsq_pkg::LD_SYM_OFF: ld_len = bsq_pkg::PULSE_GAP_T;
            default: ld_len = lock ? bsq_pkg::LOCK_DARK2_T : bsq_pkg::CODE_PAUSE_T;
        endcase
    end
    wire ld_end = tick_reg && (lt_reg >= ld_len - bsq_pkg::TW'(1));
    always_comb
    begin
        ld_next = ld_reg;
        if (ld_end)
        begin
            case (ld_reg)
                bsq_pkg::LD_LIT: ld_next = bsq_pkg::LD_DARK1;
                bsq_pkg::LD_DARK1: ld_next = bsq_pkg::LD_SYM_ON;
                bsq_pkg::LD_SYM_ON:
                    ld_next = last_sym ? bsq_pkg::LD_DARK2 : bsq_pkg::LD_SYM_OFF;
                bsq_pkg::LD_SYM_OFF: ld_next = bsq_pkg::LD_SYM_ON;
                bsq_pkg::LD_DARK2:
                    ld_next = lock ? bsq_pkg::LD_LIT : bsq_pkg::LD_SYM_ON;
                default: ld_next = bsq_pkg::LD_SYM_ON;
            endcase
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ld_reg <= bsq_pkg::LD_SYM_ON;
            lt_reg <= '0;
            sym_reg <= '0;
            led_reg <= 1'b0;
        end
        else if (st_next != st_reg)
        begin
            // a phase change restarts the pattern so no half code is shown
            ld_reg <= (st_next == bsq_pkg::ST_LOCK) ? bsq_pkg::LD_LIT : bsq_pkg::LD_SYM_ON;
            lt_reg <= '0;
            sym_reg <= '0;
            led_reg <= 1'b0;
        end
        else
        begin
            ld_reg <= ld_next;
            lt_reg <= ld_end ? '0 : (tick_reg ? lt_reg + bsq_pkg::TW'(1) : lt_reg);
            if (ld_end && ld_reg == bsq_pkg::LD_SYM_OFF)
                sym_reg <= sym_reg + 3'h1;
            else if (ld_end && ld_reg != bsq_pkg::LD_SYM_ON)
                sym_reg <= '0;
            led_reg <= (ld_reg == bsq_pkg::LD_LIT) || (ld_reg == bsq_pkg::LD_SYM_ON);
        end
    end
    assign led_o = led_reg;

    // bus registers: one cycle answer, unmapped reads give zero
    wire [31:0] stat_word = {20'h00000, alarm_o, preheater_o, valve2_o, valve1_o,
                             1'b0, cause_reg, st_reg};
    wire [31:0] rd_word = (adr_i == bsq_pkg::CTRL_ADDR) ? {31'h0, two_stage_reg} :
                          (adr_i == bsq_pkg::STAT_ADDR) ? stat_word : 32'h0;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
            two_stage_reg <= bsq_pkg::CTRL_RESET;
        end
        else
        begin
            ack_reg <= bus_req;
            dat_reg <= bus_req ? rd_word : dat_reg;
            if (ctrl_wr)
                two_stage_reg <= dat_i[bsq_pkg::CTRL_TWO_STAGE];
        end
    end
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
endmodule : bsq_sequencer

//--- src/bsq_pkg.sv
// What this block does
// - preheat warm-up limited to 400 seconds
// - pre-purge/pre-ignition lasts 15 s, fan+ignition on
// - stray-light window 5 s, safety time 5 s
// - ignition 7 s after valve one; valve two +20s
// - led shows current phase code when not locked
// - every phase has a pulse code; wait/preheat share one, safety/post share one
// - lockout keeps the led lit for 10 s between cause codes
// - every 10 s: dark 0.6 s, cause code, dark 1.2 s
// - lockout light cycle repeats until reset
// - lockout cause kept in nonvolatile memory
// - no flame by safety end locks out
// - flame in stray-light window locks out
// - no thermostat close in 400 s locks out
// - manual lockout has own code
// - one button clears lockout and forces lockout
// - undervoltage stops operation, no self restart meanwhile
// - stray-light check at end of pre-purge
// - button held over 3 s, released, shuts down
// - undervoltage cleared starts a new start-up
package bsq_pkg;
    // timebase
    localparam int CLK_NS = 40;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_NS;
    localparam int TW = 12;
    // documented times in milliseconds, converted to ticks
    localparam int PREHEAT_MAX_MS = 400000;
    localparam int PREPURGE_MS = 15000;
    localparam int STRAY_WIN_MS = 5000;
    localparam int SAFETY_MS = 5000;
    localparam int POST_IGN_MS = 7000;
    localparam int STAGE2_MS = 20000;
    localparam int LOCK_LIT_MS = 10000;
    localparam int LOCK_DARK1_MS = 600;
    localparam int LOCK_DARK2_MS = 1200;
    localparam int BTN_HOLD_MS = 3000;
    localparam int PULSE_SHORT_MS = 200;
    localparam int PULSE_LONG_MS = 600;
    localparam int PULSE_GAP_MS = 200;
    localparam int CODE_PAUSE_MS = 1000;
    localparam logic [TW-1:0] PREHEAT_MAX_T = TW'(PREHEAT_MAX_MS / TICK_MS);
    localparam logic [TW-1:0] PREPURGE_T = TW'(PREPURGE_MS / TICK_MS);
    localparam logic [TW-1:0] STRAY_START_T = TW'((PREPURGE_MS - STRAY_WIN_MS) / TICK_MS);
    localparam logic [TW-1:0] SAFETY_T = TW'(SAFETY_MS / TICK_MS);
    localparam logic [TW-1:0] POST_REST_T = TW'((POST_IGN_MS - SAFETY_MS) / TICK_MS);
    localparam logic [TW-1:0] STAGE2_REST_T = TW'((STAGE2_MS - POST_IGN_MS) / TICK_MS);
    localparam logic [TW-1:0] LOCK_LIT_T = TW'(LOCK_LIT_MS / TICK_MS);
    localparam logic [TW-1:0] LOCK_DARK1_T = TW'(LOCK_DARK1_MS / TICK_MS);
    localparam logic [TW-1:0] LOCK_DARK2_T = TW'(LOCK_DARK2_MS / TICK_MS);
    localparam logic [TW-1:0] BTN_HOLD_T = TW'(BTN_HOLD_MS / TICK_MS);
    localparam logic [TW-1:0] PULSE_SHORT_T = TW'(PULSE_SHORT_MS / TICK_MS);
    localparam logic [TW-1:0] PULSE_LONG_T = TW'(PULSE_LONG_MS / TICK_MS);
    localparam logic [TW-1:0] PULSE_GAP_T = TW'(PULSE_GAP_MS / TICK_MS);
    localparam logic [TW-1:0] CODE_PAUSE_T = TW'(CODE_PAUSE_MS / TICK_MS);
    // wishbone register map
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam int CTRL_TWO_STAGE = 0;
    localparam int STAT_CAUSE_LSB = 4;
    localparam int STAT_OUT_LSB = 8;
    localparam logic CTRL_RESET = 1'b0;
    // sequencer phases
    typedef enum logic [3:0] {
        ST_WAIT = 4'h0, ST_PREHEAT = 4'h1, ST_PURGE = 4'h2, ST_SAFETY = 4'h3,
        ST_POST = 4'h4, ST_STAGE2 = 4'h5, ST_RUN = 4'h6, ST_UNDERV = 4'h7,
        ST_DEFECT = 4'h8, ST_LOCK = 4'h9
    } bsq_state_t;
    // lockout causes, zero means none stored
    typedef enum logic [2:0] {
        CA_NONE = 3'h0, CA_NOFLAME = 3'h1, CA_STRAY = 3'h2, CA_THERMO = 3'h3,
        CA_MANUAL = 3'h4
    } bsq_cause_t;
    // led sequencer states
    typedef enum logic [2:0] {
        LD_LIT = 3'h0, LD_DARK1 = 3'h1, LD_SYM_ON = 3'h2, LD_SYM_OFF = 3'h3,
        LD_DARK2 = 3'h4
    } bsq_led_t;
    // pulse code: count of symbols and a mask of long ones, first symbol in bit 0
    localparam int CODE_W = 8;
endpackage : bsq_pkg

//--- testbench/bsq_sequencer_properties.sv
module bsq_sequencer_properties #(
    parameter int TICK_CYCLES = 4
) (
    // clock, reset, bus request and undervoltage input
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic undervolt_i,
    // design outputs
    input wire logic ack_o,
    input wire logic motor_o,
    input wire logic ignition_o,
    input wire logic valve1_o,
    input wire logic valve2_o,
    input wire logic alarm_o,
    input wire logic led_o,
    input wire logic nv_wr_o,
    input wire logic [2:0] nv_cause_o
);
    // a partial first tick and the output register allow one tick plus eight cycles of slack
    localparam int PURGE_LO = 150 * TICK_CYCLES - TICK_CYCLES - 8;
    localparam int PURGE_HI = 150 * TICK_CYCLES + TICK_CYCLES + 8;
    int purge_cnt;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !motor_o || valve1_o)
            purge_cnt <= 0;
        else
            purge_cnt <= purge_cnt + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_purge_drive: assert property ($rose(motor_o) |-> ignition_o && !valve1_o)
        else $error("purge started without ignition or with fuel open");
    a_purge_length: assert property ($rose(valve1_o) |-> purge_cnt inside {[PURGE_LO:PURGE_HI]})
        else $error("purge length wrong when valve one opened");
    a_ignite_holds: assert property ($rose(valve1_o) |-> ignition_o [*8])
        else $error("ignition dropped as valve one opened");
    a_stage_order: assert property (valve2_o |-> valve1_o)
        else $error("valve two open without valve one");
    a_underv_stop: assert property (undervolt_i [*8] |-> !valve1_o && !ignition_o && !motor_o)
        else $error("burner still driven under low mains");
    a_lock_lit: assert property ($rose(alarm_o) |-> led_o [*8])
        else $error("indicator not lit on lockout");
    a_cause_store: assert property (nv_wr_o && nv_cause_o != 3'h0 |-> ##[0:2] alarm_o)
        else $error("cause stored without lockout");
    cover property ($rose(valve2_o));
    cover property ($rose(alarm_o));
    cover property (nv_wr_o && nv_cause_o == 3'h0);
endmodule : bsq_sequencer_properties

bind bsq_sequencer bsq_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .undervolt_i(undervolt_i),
    .ack_o(ack_o), .motor_o(motor_o), .ignition_o(ignition_o), .valve1_o(valve1_o),
    .valve2_o(valve2_o), .alarm_o(alarm_o), .led_o(led_o), .nv_wr_o(nv_wr_o),
    .nv_cause_o(nv_cause_o)
);

//--- testbench/bsq_field_model.sv
module bsq_field_model (
    // burner side as driven by the sequencer
    input wire logic clk_i,
    input wire logic preheater_i,
    input wire logic motor_i,
    input wire logic valve1_i,
    input wire logic nv_wr_i,
    input wire logic [2:0] nv_cause_i,
    // bench knobs: warm-up length and light mode (0 flame, 1 none, 2 stray)
    input wire logic [15:0] heat_delay_i,
    input wire logic [1:0] light_mode_i,
    // back to the sequencer
    output logic preheat_ready_o,
    output logic flame_o,
    output logic [2:0] nv_cause_o
);
    logic [15:0] heat_reg;
    logic [3:0] flame_dly_reg;
    // the store ignores reset on purpose, it outlives a power cycle
    logic [2:0] nv_reg = 3'h0;
    always_ff @(posedge clk_i)
    begin
        heat_reg <= preheater_i ? (heat_reg == 16'hffff ? heat_reg : heat_reg + 16'h1) : 16'h0;
        flame_dly_reg <= {flame_dly_reg[2:0], valve1_i};
        if (nv_wr_i)
            nv_reg <= nv_cause_i;
    end
    assign preheat_ready_o = preheater_i && heat_reg > heat_delay_i;
    assign flame_o = light_mode_i == 2'h0 ? flame_dly_reg[3] : light_mode_i == 2'h2 && motor_i;
    assign nv_cause_o = nv_reg;
endmodule : bsq_field_model

//--- testbench/bsq_sequencer_bench.sv
module bsq_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic thermostat_i = 1'b0;
    logic button_i = 1'b0;
    logic undervolt_i = 1'b0;
    logic fault_i = 1'b0;
    logic [15:0] heat_delay = 16'h0014;
    logic [1:0] light_mode = 2'h0;
    logic [31:0] dat_o;
    logic ack_o, nv_wr_o, motor_o, ignition_o, valve1_o, valve2_o, preheater_o, alarm_o, led_o;
    logic preheat_ready_i, flame_i;
    logic [2:0] nv_cause_i, nv_cause_o;
    // watched outputs: 0 motor, 1 ignition, 2 valve1, 3 valve2, 4 alarm, 5 led
    logic [5:0] outs;
    int err_total = 0;
    int checked = 0;
    assign outs = {led_o, alarm_o, valve2_o, valve1_o, ignition_o, motor_o};
    always #20 clk_i = ~clk_i;
    bsq_sequencer #(.TICK_CYCLES(T)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .thermostat_i, .preheat_ready_i, .flame_i, .button_i, .undervolt_i,
        .fault_i, .nv_cause_i, .nv_wr_o, .nv_cause_o, .motor_o, .ignition_o, .valve1_o, .valve2_o,
        .preheater_o, .alarm_o, .led_o);
    bsq_field_model u_field (.clk_i(clk_i), .preheater_i(preheater_o), .motor_i(motor_o),
        .valve1_i(valve1_o), .nv_wr_i(nv_wr_o), .nv_cause_i(nv_cause_o), .heat_delay_i(heat_delay),
        .light_mode_i(light_mode), .preheat_ready_o(preheat_ready_i), .flame_o(flame_i),
        .nv_cause_o(nv_cause_i));
    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1)
        begin
            err_total++;
            $display("unexpected at %0t: ack %h expected %h", $time, ack_o, 1'b1);
            finish_test();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic status(output logic [31:0] q);
        wb(1'b0, 4'h4, 32'h0, q);
    endtask : status
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // a partial first tick plus input synchronisers give the slack
    task automatic chk_time(input int n, input int exp);
        checked++;
        if (n < exp - T - 12 || n > exp + T + 12)
        begin
            err_total++;
            $display("unexpected at %0t: took %h cycles expected %h", $time, n, exp);
        end
    endtask : chk_time
    task automatic wait_out(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (outs[i] !== v && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim)
        begin
            err_total++;
            $display("unexpected at %0t: output %h is %h", $time, i, outs[i]);
            finish_test();
        end
    endtask : wait_out
    task automatic wait_state(input logic [3:0] s, input int lim);
        logic [31:0] q;
        int n;
        n = 0;
        status(q);
        while (q[3:0] !== s && n < lim)
        begin
            status(q);
            n++;
        end
        chk({28'h0, q[3:0]}, {28'h0, s});
        if (q[3:0] !== s)
            finish_test();
    endtask : wait_state
    task automatic led_count(output int r);
        logic prev;
        r = 0;
        prev = led_o;
        repeat (60 * T)
        begin
            @(posedge clk_i);
            r += (led_o && !prev) ? 1 : 0;
            prev = led_o;
        end
    endtask : led_count
    task automatic press(input int ticks);
        button_i <= 1'b1;
        tick(ticks * T);
        button_i <= 1'b0;
        @(posedge clk_i);
    endtask : press
    initial
    begin
        logic [31:0] q;
        int n;
        tick(6);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        thermostat_i <= 1'b1;
        wait_state(4'h1, 100);
        wait_out(0, 1'b1, 2000, n);
        wait_out(2, 1'b1, 1000, n);
        chk_time(n, 150 * T);
        wait_out(1, 1'b0, 1000, n);
        chk_time(n, 70 * T);
        status(q);
        chk(q & 32'h37f, 32'h106);
        wb(1'b1, 4'h0, 32'h1, q);
        wb(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h1);
        thermostat_i <= 1'b0;
        wait_state(4'h0, 100);
        thermostat_i <= 1'b1;
        wait_out(2, 1'b1, 3000, n);
        wait_out(3, 1'b1, 2000, n);
        chk_time(n, 200 * T);
        status(q);
        chk(q & 32'h37f, 32'h306);
        thermostat_i <= 1'b0;
        wait_state(4'h0, 100);
        light_mode <= 2'h1;
        thermostat_i <= 1'b1;
        wait_out(2, 1'b1, 3000, n);
        wait_out(4, 1'b1, 1000, n);
        chk_time(n, 50 * T);
        chk({29'h0, nv_cause_i}, 32'h1);
        wait_out(5, 1'b0, 1000, n);
        chk_time(n, 100 * T);
        led_count(n);
        chk(32'(n), 32'h6);
        rst_i <= 1'b1;
        tick(6);
        rst_i <= 1'b0;
        wait_state(4'h9, 20);
        status(q);
        chk(q & 32'h70, 32'h10);
        light_mode <= 2'h2;
        press(2);
        wait_out(0, 1'b1, 200, n);
        chk({29'h0, nv_cause_i}, 32'h0);
        wait_out(4, 1'b1, 1000, n);
        chk_time(n, 100 * T);
        status(q);
        chk(q & 32'h37f, 32'h29);
        wait_out(5, 1'b0, 1000, n);
        led_count(n);
        chk(32'(n), 32'h4);
        light_mode <= 2'h0;
        press(2);
        wait_state(4'h6, 700);
        press(10);
        tick(20);
        status(q);
        chk(q & 32'h7f, 32'h6);
        press(40);
        wait_out(4, 1'b1, 100, n);
        status(q);
        chk(q & 32'h7f, 32'h49);
        wait_out(5, 1'b0, 1000, n);
        led_count(n);
        chk(32'(n), 32'h6);
        press(2);
        wait_out(0, 1'b1, 200, n);
        undervolt_i <= 1'b1;
        wait_state(4'h7, 20);
        tick(100 * T);
        status(q);
        chk(q & 32'h30f, 32'h7);
        undervolt_i <= 1'b0;
        wait_out(0, 1'b1, 300, n);
        fault_i <= 1'b1;
        wait_state(4'h8, 20);
        fault_i <= 1'b0;
        heat_delay <= 16'hffff;
        thermostat_i <= 1'b0;
        wait_state(4'h0, 100);
        thermostat_i <= 1'b1;
        wait_out(4, 1'b1, 17000, n);
        chk_time(n, 4000 * T);
        status(q);
        chk(q & 32'hf7f, 32'hc39);
        finish_test();
    end
endmodule : bsq_sequencer_bench
